// ===== logic/blpwm_channel.sv
// One channel: duty ramp and PWM with on-time extension
`timescale 1ns/1ps
module blpwm_channel #(
  parameter int unsigned P_STRETCH_CYCLES = blpwm_pkg::STRETCH_CYCLES
) (
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_arst_n,
  // Setting and timebase
  input  wire blpwm_pkg::blpwm_cfg_t i_cfg,
  input  wire logic [4:0]        i_slot_idx,
  input  wire logic              i_ramp_tick,
  // Results
  output logic [5:0]             o_eff_duty,
  output logic                   o_pwm
);
  import blpwm_pkg::*;

  localparam int unsigned SW = $clog2(P_STRETCH_CYCLES + 1);

  logic [5:0]    target;
  logic [5:0]    eff_reg;
  logic          raw_on;
  logic [SW-1:0] stretch_reg;
  logic          pwm_reg;

  // Top bit set means continuously on
  assign target = i_cfg.duty_code[5] ? DUTY_FULL : {1'b0, i_cfg.duty_code[4:0]};
  assign raw_on = {1'b0, i_slot_idx} < eff_reg;

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      eff_reg <= 6'h00;
    else if (!i_cfg.ramp_enable)
      eff_reg <= target;
    else if (i_ramp_tick && eff_reg < target)
      eff_reg <= eff_reg + 6'h01;
    else if (i_ramp_tick && eff_reg > target)
      eff_reg <= eff_reg - 6'h01;
  end

  // Hold the sink on a while after each on period
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      stretch_reg <= '0;
    else if (raw_on)
      stretch_reg <= SW'(P_STRETCH_CYCLES);
    else if (stretch_reg != '0)
      stretch_reg <= stretch_reg - SW'(1);
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      pwm_reg <= 1'b0;
    else
      pwm_reg <= raw_on || (stretch_reg != '0);
  end

  assign o_eff_duty = eff_reg;
  assign o_pwm      = pwm_reg;

  chk_ramp_step: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_cfg.ramp_enable && i_ramp_tick && eff_reg != target && $stable(i_cfg))
    |=> (eff_reg == $past(eff_reg) + 6'h01 || eff_reg == $past(eff_reg) - 6'h01))
    else $error("ramp did not move one step");
  chk_ramp_hold: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_cfg.ramp_enable && (!i_ramp_tick || eff_reg == target)) |=> $stable(eff_reg))
    else $error("ramp moved off a tick or past target");
  chk_direct_set: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !i_cfg.ramp_enable |=> eff_reg == $past(target))
    else $error("duty not applied at once");
  chk_full_on: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (eff_reg == DUTY_FULL) [*2] |-> pwm_reg)
    else $error("full duty not continuous");
  chk_stretch_on: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    $fell(raw_on) |=> pwm_reg ##1 pwm_reg)
    else $error("on period not lengthened");

endmodule : blpwm_channel

// ===== logic/blpwm_dimmer.sv
// Backlight dimmer top: APB registers, timebase, time sharing, sink drive
`timescale 1ns/1ps
module blpwm_dimmer #(
  parameter int unsigned P_SLOT_CYCLES    = blpwm_pkg::SLOT_CYCLES,
  parameter int unsigned P_STRETCH_CYCLES = blpwm_pkg::STRETCH_CYCLES
) (
  // Clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_arst_n,
  // APB slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [11:0]           i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic                       o_pready,
  output logic [31:0]                o_prdata,
  output logic                       o_pslverr,
  // Sink drive: 0 main display, 1 aux display, 2 keypad
  output blpwm_pkg::blpwm_drive_t [blpwm_pkg::NUM_CH-1:0] o_drive
);
  import blpwm_pkg::*;

  localparam int unsigned SCW = $clog2(P_SLOT_CYCLES + 1);
  localparam int unsigned HCW = $clog2(SHARE_CYCLES + 1);
  localparam int unsigned FCW = $clog2(FRAMES_PER_STEP + 1);

  blpwm_cfg_t [NUM_CH-1:0]   cfg_reg;
  blpwm_drive_t [NUM_CH-1:0] drive_reg;
  blpwm_drive_t [NUM_CH-1:0] drive_next;
  logic [NUM_CH-1:0][5:0]    eff_duty;
  logic [NUM_CH-1:0]         pwm;
  logic [NUM_CH-1:0]         channel_enabled;
  logic [NUM_CH-1:0]         has_lower;
  logic [1:0]                en_cnt;

  logic [SCW-1:0] slot_cnt_reg;
  logic [4:0]     slot_idx_reg;
  logic [FCW-1:0] frame_cnt_reg;
  logic           ramp_tick_reg;
  logic           slot_wrap;
  logic [HCW-1:0] share_cnt_reg;
  logic           share_phase_reg;

  logic           pready_reg;
  logic [31:0]    prdata_reg;
  logic           pslverr_reg;
  logic [31:0]    rd_mux;
  logic           addr_hit;
  logic           setup;
  logic           wr_fire;

  // Free-running timebase: slot, frame, ramp tick
  assign slot_wrap = (slot_cnt_reg == SCW'(P_SLOT_CYCLES - 1));

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      slot_cnt_reg <= '0;
    else if (slot_wrap)
      slot_cnt_reg <= '0;
    else
      slot_cnt_reg <= slot_cnt_reg + SCW'(1);
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      slot_idx_reg <= 5'h00;
    else if (slot_wrap)
      slot_idx_reg <= slot_idx_reg + 5'h01;
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      frame_cnt_reg <= '0;
      ramp_tick_reg <= 1'b0;
    end
    else
    begin
      // Tick only at a frame boundary
      ramp_tick_reg <= 1'b0;
      if (slot_wrap && slot_idx_reg == 5'h1f)
      begin
        if (frame_cnt_reg == FCW'(FRAMES_PER_STEP - 1))
        begin
          frame_cnt_reg <= '0;
          ramp_tick_reg <= 1'b1;
        end
        else
          frame_cnt_reg <= frame_cnt_reg + FCW'(1);
      end
    end
  end

  // Time-share alternation
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      share_cnt_reg   <= '0;
      share_phase_reg <= 1'b0;
    end
    else if (share_cnt_reg == HCW'(SHARE_CYCLES - 1))
    begin
      share_cnt_reg   <= '0;
      share_phase_reg <= ~share_phase_reg;
    end
    else
      share_cnt_reg <= share_cnt_reg + HCW'(1);
  end

  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    blpwm_channel #(
      .P_STRETCH_CYCLES (P_STRETCH_CYCLES)
    ) u_channel (
      .i_clock     (i_clock),
      .i_arst_n    (i_arst_n),
      .i_cfg       (cfg_reg[g]),
      .i_slot_idx  (slot_idx_reg),
      .i_ramp_tick (ramp_tick_reg),
      .o_eff_duty  (eff_duty[g]),
      .o_pwm       (pwm[g])
    );
    // Enabled while set or still ramping down
    assign channel_enabled[g] = (cfg_reg[g].duty_code != 6'h00) || (eff_duty[g] != 6'h00);
  end

  assign has_lower = {channel_enabled[1] | channel_enabled[0], channel_enabled[0], 1'b0};

  always_comb
  begin
    en_cnt = 2'd0;
    for (int i = 0; i < NUM_CH; i++)
      en_cnt = en_cnt + 2'(channel_enabled[i]);
    for (int i = 0; i < NUM_CH; i++)
    begin
      drive_next[i].current_level_code = cfg_reg[i].current_level_code;
      drive_next[i].high_range_select  = cfg_reg[i].high_range_select;
      drive_next[i].dbl                = (en_cnt == 2'd2);
      drive_next[i].on = pwm[i] && channel_enabled[i] && (en_cnt != 2'd3)
                         && (en_cnt != 2'd2 || has_lower[i] == share_phase_reg);
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      drive_reg <= '0;
    else
      drive_reg <= drive_next;
  end

  // APB slave, one wait-free access phase
  assign setup    = i_psel && !i_penable;
  assign wr_fire  = i_psel && i_penable && pready_reg && i_pwrite && !pslverr_reg;
  assign addr_hit = (i_paddr == OFS_MAIN) || (i_paddr == OFS_AUX) || (i_paddr == OFS_KEY)
                    || (i_paddr == OFS_STATUS);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (i_paddr)
      OFS_MAIN:   rd_mux[CFG_W-1:0] = cfg_reg[0];
      OFS_AUX:    rd_mux[CFG_W-1:0] = cfg_reg[1];
      OFS_KEY:    rd_mux[CFG_W-1:0] = cfg_reg[2];
      OFS_STATUS:
      begin
        for (int i = 0; i < NUM_CH; i++)
          rd_mux[i*STAT_CH_STEP +: 6] = eff_duty[i];
        rd_mux[STAT_EN_LSB +: NUM_CH] = channel_enabled;
        rd_mux[STAT_SH_BIT]           = (en_cnt == 2'd2);
      end
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !addr_hit;
      if (setup && !i_pwrite)
        prdata_reg <= rd_mux;
      else if (!setup)
        prdata_reg <= 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      cfg_reg <= {NUM_CH{CFG_RST}};
    else if (wr_fire)
    begin
      if (i_paddr == OFS_MAIN)
        cfg_reg[0] <= i_pwdata[CFG_W-1:0];
      if (i_paddr == OFS_AUX)
        cfg_reg[1] <= i_pwdata[CFG_W-1:0];
      if (i_paddr == OFS_KEY)
        cfg_reg[2] <= i_pwdata[CFG_W-1:0];
    end
  end

  assign o_pready  = pready_reg;
  assign o_prdata  = prdata_reg;
  assign o_pslverr = pslverr_reg;
  assign o_drive   = drive_reg;

  chk_three_all_off: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (en_cnt == 2'd3) |=> (!drive_reg[0].on && !drive_reg[1].on && !drive_reg[2].on))
    else $error("driver active with three channels enabled");
  chk_share_exclusive: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (en_cnt == 2'd2) |=> $onehot0({drive_reg[0].on, drive_reg[1].on, drive_reg[2].on}))
    else $error("two shared channels on together");
  chk_share_toggle: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    $rose(share_phase_reg) |-> ##[1:600] $fell(share_phase_reg))
    else $error("share phase stuck");
  chk_double_current: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (en_cnt == 2'd2) |=> (drive_reg[0].dbl && drive_reg[1].dbl && drive_reg[2].dbl))
    else $error("current not doubled while sharing");
  chk_single_normal: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (en_cnt < 2'd2) |=> !drive_reg[0].dbl)
    else $error("current doubled without sharing");
  chk_level_pass: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    1'b1 |=> (drive_reg[1].current_level_code == $past(cfg_reg[1].current_level_code)
              && drive_reg[1].high_range_select == $past(cfg_reg[1].high_range_select)))
    else $error("current code not forwarded");
  chk_tick_align: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    ramp_tick_reg |-> (slot_idx_reg == 5'h00 && slot_cnt_reg == '0))
    else $error("ramp tick off a frame boundary");
  chk_slot_advance: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    slot_wrap |=> slot_idx_reg == $past(slot_idx_reg) + 5'h01)
    else $error("slot index did not advance");
  chk_apb_ready: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    setup |=> (o_pready ##1 !o_pready || setup))
    else $error("pready not one access cycle");

  // Register bus checks
  chk_write_main: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (wr_fire && i_paddr == OFS_MAIN)
    |=> cfg_reg[0] == $past(i_pwdata[CFG_W-1:0]))
    else $error("main setting not written");
  chk_write_aux: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (wr_fire && i_paddr == OFS_AUX)
    |=> cfg_reg[1] == $past(i_pwdata[CFG_W-1:0]))
    else $error("aux setting not written");
  chk_write_key: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (wr_fire && i_paddr == OFS_KEY)
    |=> cfg_reg[2] == $past(i_pwdata[CFG_W-1:0]))
    else $error("keypad setting not written");
  chk_status_readonly: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (wr_fire && i_paddr == OFS_STATUS) |=> $stable(cfg_reg))
    else $error("status write changed a setting");
  chk_unmapped_err: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (setup && !addr_hit) |=> (o_pready && o_pslverr && o_prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
  chk_unmapped_keep: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_psel && i_penable && pslverr_reg) |=> $stable(cfg_reg))
    else $error("refused write changed a setting");
  chk_rdata_idle: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !o_pready |-> o_prdata == 32'h0000_0000)
    else $error("read data outside access");
  chk_read_main: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (setup && !i_pwrite && i_paddr == OFS_MAIN)
    |=> o_prdata == 32'($past(cfg_reg[0])))
    else $error("main setting read wrong");
  chk_read_enabled: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (setup && !i_pwrite && i_paddr == OFS_STATUS)
    |=> o_prdata[STAT_EN_LSB +: NUM_CH] == $past(channel_enabled))
    else $error("enabled flags read wrong");

  // Drive and timebase checks
  chk_off_disabled: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    1'b1 |=> ((~$past(channel_enabled)
              & {drive_reg[2].on, drive_reg[1].on, drive_reg[0].on}) == 3'b000))
    else $error("disabled channel driven");
  chk_single_follow: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (en_cnt == 2'd1)
    |=> ({drive_reg[2].on, drive_reg[1].on, drive_reg[0].on} == $past(pwm & channel_enabled)))
    else $error("single channel drive wrong");
  chk_share_lower: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (en_cnt == 2'd2 && channel_enabled[0] && pwm[0])
    |=> drive_reg[0].on == !$past(share_phase_reg))
    else $error("lower shared channel off phase");
  chk_share_upper: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (en_cnt == 2'd2 && channel_enabled[0] && channel_enabled[1] && pwm[1])
    |=> drive_reg[1].on == $past(share_phase_reg))
    else $error("upper shared channel off phase");
  chk_level_main: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    1'b1 |=> (drive_reg[0].current_level_code == $past(cfg_reg[0].current_level_code)
              && drive_reg[0].high_range_select == $past(cfg_reg[0].high_range_select)))
    else $error("main current code not forwarded");
  chk_level_key: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    1'b1 |=> (drive_reg[2].current_level_code == $past(cfg_reg[2].current_level_code)
              && drive_reg[2].high_range_select == $past(cfg_reg[2].high_range_select)))
    else $error("keypad current code not forwarded");
  chk_frame_bound: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    frame_cnt_reg < FCW'(FRAMES_PER_STEP))
    else $error("frame count out of range");
  chk_share_bound: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    share_cnt_reg < HCW'(SHARE_CYCLES))
    else $error("share count out of range");

endmodule : blpwm_dimmer

// ===== logic/blpwm_pkg.sv
// Constants and types of the backlight PWM dimmer
package blpwm_pkg;

  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned PWM_RATE_HZ     = 256;
  localparam int unsigned RAMP_RATE_HZ    = 64;
  localparam int unsigned DUTY_STEPS      = 32;
  localparam int unsigned NUM_CH          = 3;
  // One duty slot; a longest time, so it rounds down
  localparam int unsigned SLOT_CYCLES     = CLK_HZ / (PWM_RATE_HZ * DUTY_STEPS);
  localparam int unsigned FRAMES_PER_STEP = PWM_RATE_HZ / RAMP_RATE_HZ;
  // Boost start-up cover, half a slot
  localparam int unsigned STRETCH_CYCLES  = SLOT_CYCLES / 2;
  // Time-share half period, about 195 kHz alternation
  localparam int unsigned SHARE_CYCLES    = 512;

  // Register offsets
  localparam logic [11:0] OFS_MAIN   = 12'h000;
  localparam logic [11:0] OFS_AUX    = 12'h004;
  localparam logic [11:0] OFS_KEY    = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;

  // Field positions
  localparam int unsigned CFG_W        = 11;
  localparam int unsigned STAT_CH_STEP = 8;
  localparam int unsigned STAT_EN_LSB  = 24;
  localparam int unsigned STAT_SH_BIT  = 27;

  localparam logic [5:0]  DUTY_FULL = 6'h20;
  localparam logic [CFG_W-1:0] CFG_RST = 11'h000;

  // Channel setting, same layout as the control register
  typedef struct packed {
    logic       ramp_enable;
    logic       high_range_select;
    logic [2:0] current_level_code;
    logic [5:0] duty_code;
  } blpwm_cfg_t;

  // Sink drive toward the analog current stage
  typedef struct packed {
    logic       on;
    logic       dbl;
    logic       high_range_select;
    logic [2:0] current_level_code;
  } blpwm_drive_t;

endpackage : blpwm_pkg

// ===== testbench/blpwm_dimmer_tb_top.sv
// Self-checking bench of the backlight dimmer driving an LED load model
`timescale 1ns/1ps
module blpwm_dimmer_tb_top;
  import blpwm_pkg::*;
  localparam int SLOT  = 16;
  localparam int STR   = 4;
  localparam int FRAME = 32 * SLOT;
  localparam int TICK  = 4 * FRAME;
  localparam logic [11:0] OFS [3] = '{OFS_MAIN, OFS_AUX, OFS_KEY};
  localparam logic [5:0] DUTY [6] = '{6'h01, 6'h1f, 6'h20, 6'h3f, 6'h10, 6'h00};
  logic                      i_clock, i_arst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [11:0]               i_paddr;
  logic [31:0]               i_pwdata, o_prdata, rd, r;
  blpwm_drive_t [NUM_CH-1:0] o_drive;
  logic [NUM_CH-1:0][7:0]    load_ma;
  logic [33:0]               exp_q [$];
  logic [33:0]               e;
  logic [12:0]               got;
  logic [5:0]                d;
  logic [2:0]                on_v, code;
  logic                      hi;
  int                        n_errors, comparisons, seed, k;

  blpwm_dimmer #(
    .P_SLOT_CYCLES    (SLOT),
    .P_STRETCH_CYCLES (STR)
  ) i_dut (
    .i_clock   (i_clock),
    .i_arst_n  (i_arst_n),
    .i_psel    (i_psel),
    .i_penable (i_penable),
    .i_pwrite  (i_pwrite),
    .i_paddr   (i_paddr),
    .i_pwdata  (i_pwdata),
    .o_pready  (o_pready),
    .o_prdata  (o_prdata),
    .o_pslverr (o_pslverr),
    .o_drive   (o_drive)
  );
  blpwm_led_model i_load (
    .i_drive (o_drive),
    .o_ma    (load_ma)
  );
  assign on_v = {o_drive[2].on, o_drive[1].on, o_drive[0].on};

  initial
  begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // Bus results taken in the answer cycle, compared with the oldest note
  always @(negedge i_clock)
  begin
    if (o_pready === 1'b1)
    begin
      if (exp_q.size() > 0)
      begin
        e = exp_q.pop_front();
        check("pslverr", 32'(o_pslverr), 32'(e[32]));
        if (!e[33])
          check("prdata", o_prdata, e[31:0]);
      end
    end
  end

  task automatic apb(logic wr, logic [11:0] a, logic [31:0] dat, logic chk, logic [32:0] x);
    int n;
    @(posedge i_clock);
    if (chk)
      exp_q.push_back({wr, x});
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= dat;
    @(posedge i_clock);
    i_penable <= 1'b1;
    n = 0;
    // Ready seen at the rising edge, before the design updates it
    @(posedge i_clock);
    while (o_pready !== 1'b1 && n < 20)
    begin
      @(posedge i_clock);
      n++;
    end
    if (n >= 20)
    begin
      n_errors++;
      give_verdict();
    end
    rd        = o_prdata;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic rdx(logic [11:0] a, logic [31:0] x);
    apb(1'b0, a, 32'h0, 1'b1, {1'b0, x});
  endtask : rdx

  // Write with random unused upper bits, then read back
  task automatic set(int c, logic [10:0] v);
    r = $random(seed);
    apb(1'b1, OFS[c], {r[31:11], v}, 1'b1, 33'h0);
    rdx(OFS[c], {21'h0, v});
  endtask : set

  task automatic pick();
    r = $random(seed);
    code = (r[2:0] == 3'd0) ? 3'd7 : r[2:0];
    hi = r[3];
  endtask : pick

  function automatic logic [7:0] ma_of(logic [2:0] cd, logic h, logic x2);
    return (8'(cd) * (h ? 8'd6 : 8'd3)) << x2;
  endfunction : ma_of

  // Cycles with any masked sink on; drive and current of channel c kept
  task automatic count_on(int c, logic [2:0] m, int len);
    k = 0;
    got = 13'h0;
    repeat (2 * SLOT) @(posedge i_clock);
    repeat (len)
    begin
      @(negedge i_clock);
      if (|(on_v & m) === 1'b1)
        k++;
      if (on_v[c] === 1'b1)
        got = {o_drive[c][4:0], load_ma[c]};
    end
  endtask : count_on

  task automatic poll_change(logic [5:0] from);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, OFS_STATUS, 32'h0, 1'b0, 33'h0);
      n++;
    end
    while (rd[5:0] === from && n < TICK);
    if (n >= TICK)
    begin
      n_errors++;
      give_verdict();
    end
  endtask : poll_change

  initial
  begin
    seed = 32'h1417c0ba;
    n_errors = 0;
    comparisons = 0;
    i_arst_n = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    repeat (2) @(posedge i_clock);
    i_arst_n <= 1'b1;
    // Reset values, unmapped place, read-only status
    for (int i = 0; i < 5; i++)
      apb(1'b0, 12'(4 * i), 32'h0, 1'b1, {i == 4, 32'h0});
    apb(1'b1, OFS_STATUS, 32'hffffffff, 1'b1, 33'h0);
    rdx(OFS_STATUS, 32'h0);
    // One channel at a time over the duty boundaries
    for (int i = 0; i < 6; i++)
    begin
      pick();
      set(i % 3, {1'b0, hi, code, DUTY[i]});
      d = DUTY[i][5] ? 6'd32 : DUTY[i];
      rdx(OFS_STATUS, (32'(d) << (8 * (i % 3))) | (32'(d != 0) << (24 + i % 3)));
      count_on(i % 3, 3'b001 << (i % 3), FRAME);
      check("on_cycles", 32'(k), d == 0 ? 0 : d == 32 ? FRAME : d * SLOT + STR);
      if (d != 0)
        check("drive", 32'(got), {1'b0, hi, code, ma_of(code, hi, 1'b0)});
      set(i % 3, 11'h000);
    end
    // Two channels share the supply at double current
    pick();
    set(0, {2'b00, code, 6'h20});
    set(1, {1'b0, hi, code, 6'h3f});
    rdx(OFS_STATUS, 32'h0b002020);
    count_on(0, 3'b011, 2 * FRAME);
    check("shared_on", 32'(k), 2 * FRAME);
    count_on(0, 3'b001, 2 * FRAME);
    check("main_half", 32'(k), FRAME);
    check("main_drive", 32'(got), {1'b1, 1'b0, code, ma_of(code, 1'b0, 1'b1)});
    count_on(1, 3'b010, 2 * FRAME);
    check("aux_half", 32'(k), FRAME);
    check("aux_drive", 32'(got), {1'b1, hi, code, ma_of(code, hi, 1'b1)});
    // Three enabled: nothing driven
    set(2, {2'b01, code, 6'h05});
    count_on(0, 3'b111, FRAME);
    check("three_on", 32'(k), 0);
    for (int c = 2; c >= 0; c--)
      set(c, 11'h000);
    // Ramp steps, stop at target, retarget mid-ramp
    set(0, {2'b00, code, 6'h02});
    set(0, {2'b10, code, 6'h04});
    poll_change(6'h02);
    check("ramp_first", 32'(rd[5:0]), 32'd3);
    repeat (TICK - FRAME) @(posedge i_clock);
    rdx(OFS_STATUS, 32'h01000003);
    repeat (2 * FRAME) @(posedge i_clock);
    rdx(OFS_STATUS, 32'h01000004);
    repeat (TICK + FRAME) @(posedge i_clock);
    rdx(OFS_STATUS, 32'h01000004);
    set(0, {2'b10, code, 6'h08});
    poll_change(6'h04);
    set(0, {2'b10, code, 6'h01});
    poll_change(6'h05);
    check("ramp_retarget", 32'(rd[5:0]), 32'd4);
    set(0, 11'h000);
    rdx(OFS_STATUS, 32'h0);
    give_verdict();
  end
endmodule : blpwm_dimmer_tb_top

// ===== testbench/blpwm_led_model.sv
// Load model of the LED strings: current drawn through each sink in mA
`timescale 1ns/1ps
module blpwm_led_model (
  // Sink drive
  input  wire blpwm_pkg::blpwm_drive_t [blpwm_pkg::NUM_CH-1:0] i_drive,
  // String current
  output logic [blpwm_pkg::NUM_CH-1:0][7:0]                 o_ma
);
  import blpwm_pkg::*;
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      o_ma[c] = {5'h00, i_drive[c].current_level_code} * (i_drive[c].high_range_select ? 8'h06 : 8'h03);
      if (i_drive[c].dbl)
        o_ma[c] = o_ma[c] << 1;
      if (!i_drive[c].on)
        o_ma[c] = 8'h00;
    end
  end
endmodule : blpwm_led_model
